// ==== apb_status_port.sv ====
/*
 * APB slave front: decode, zero-wait ready, error answer, request capture.
 * assumes APB master signalling synchronous to clk.
 */
`timescale 1ns/100ps
module apb_status_port
    import can_central_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire can_central_pkg::word_t paddr,
    input  wire can_central_pkg::word_t pwdata,
    output logic                       pready,
    output logic                       pslverr,
    regbus_if.front                    bus
);
    logic ro_sel;

    assign bus.setup     = psel & ~penable;
    assign bus.setup_sel = decode_addr(paddr);
    assign bus.commit    = pready & psel & penable;
    assign ro_sel = (bus.setup_sel == SEL_TX) ||
                    (bus.setup_sel == SEL_RX) ||
                    (bus.setup_sel == SEL_MISC);

    // ready always follows setup by one cycle, so no wait states
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            bus.cmt_sel   <= SEL_NONE;
            bus.cmt_write <= 1'b0;
            bus.cmt_wdata <= '0;
        end
        else
        begin
            pready <= bus.setup;
            if (bus.setup)
            begin
                bus.cmt_sel   <= bus.setup_sel;
                bus.cmt_write <= pwrite;
                bus.cmt_wdata <= pwdata;
                // writes to the three read-only status words, and any unmapped access, are refused with an error
                pslverr <= (bus.setup_sel == SEL_NONE) ||
                           (pwrite && ro_sel);
            end
        end
    end
endmodule : apb_status_port

// ==== can_central_pkg.sv ====
/*
 * constants, types and address decode for the central CAN status bank.
 * assumes a 32-bit APB master and two CAN controllers as flag sources.
 */
package can_central_pkg;

    localparam int N_CTL = 2;
    localparam int EVT_W = 10;

    typedef logic [31:0] word_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_TX,
        SEL_RX,
        SEL_MISC,
        SEL_EVT,
        SEL_MASK
    } reg_sel_t;

    // byte addresses of the bank
    localparam word_t ADDR_TX   = 32'hE004_0000;
    localparam word_t ADDR_RX   = 32'hE004_0004;
    localparam word_t ADDR_MISC = 32'hE004_0008;
    localparam word_t ADDR_EVT  = 32'hE004_000C;
    localparam word_t ADDR_MASK = 32'hE004_0010;

    // lane base of each status byte
    localparam int LANE0 = 0;
    localparam int LANE1 = 8;
    localparam int LANE2 = 16;

    // reset values of the mirrored flags
    localparam logic [N_CTL-1:0] RST_LOW  = 2'h0;
    localparam logic [N_CTL-1:0] RST_HIGH = 2'h3;

    // event bit bases, two bits each
    localparam int EV_RXRDY = 0;
    localparam int EV_OVR   = 2;
    localparam int EV_ERR   = 4;
    localparam int EV_BUS   = 6;
    localparam int EV_TXC   = 8;

    function automatic reg_sel_t decode_addr(input word_t addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[31:2] == ADDR_TX[31:2])   sel = SEL_TX;
        if (addr[31:2] == ADDR_RX[31:2])   sel = SEL_RX;
        if (addr[31:2] == ADDR_MISC[31:2]) sel = SEL_MISC;
        if (addr[31:2] == ADDR_EVT[31:2])  sel = SEL_EVT;
        if (addr[31:2] == ADDR_MASK[31:2]) sel = SEL_MASK;
        return sel;
    endfunction : decode_addr

endpackage : can_central_pkg

// ==== central_can_status_regs.sv ====
/*
 * central CAN status bank: mirrors per-controller status flags into three
 * read-only registers, plus event flags with mask and interrupt, on APB.
 * assumes the controller flags are synchronous to clk and that the APB
 * master byte/halfword reads take their lanes from the full word.
 */
// Design decision made here: register access over APB.
`timescale 1ns/100ps

module central_can_status_regs
    import can_central_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire can_central_pkg::word_t paddr,
    input  wire can_central_pkg::word_t pwdata,
    output logic                       pready,
    output can_central_pkg::word_t     prdata,
    output logic                       pslverr,
    input  wire logic                  ctl1_transmitting,
    input  wire logic                  ctl2_transmitting,
    input  wire logic                  ctl1_tx_buffers_free,
    input  wire logic                  ctl2_tx_buffers_free,
    input  wire logic                  ctl1_tx_complete,
    input  wire logic                  ctl2_tx_complete,
    input  wire logic                  ctl1_receiving,
    input  wire logic                  ctl2_receiving,
    input  wire logic                  ctl1_rx_frame_ready,
    input  wire logic                  ctl2_rx_frame_ready,
    input  wire logic                  ctl1_rx_overrun,
    input  wire logic                  ctl2_rx_overrun,
    input  wire logic                  ctl1_error_warning,
    input  wire logic                  ctl2_error_warning,
    input  wire logic                  ctl1_bus_state,
    input  wire logic                  ctl2_bus_state,
    output logic                       irq
);
    import can_central_pkg::*;

    // ****************************************************************
    // source gathering and mirrors
    // ****************************************************************

    logic [N_CTL-1:0] src_ts;
    logic [N_CTL-1:0] src_tbs;
    logic [N_CTL-1:0] src_tcs;
    logic [N_CTL-1:0] src_rs;
    logic [N_CTL-1:0] src_rb;
    logic [N_CTL-1:0] src_dos;
    logic [N_CTL-1:0] src_err;
    logic [N_CTL-1:0] src_bus;
    logic [N_CTL-1:0] m_ts;
    logic [N_CTL-1:0] m_tbs;
    logic [N_CTL-1:0] m_tcs;
    logic [N_CTL-1:0] m_rs;
    logic [N_CTL-1:0] m_rb;
    logic [N_CTL-1:0] m_dos;
    logic [N_CTL-1:0] m_err;
    logic [N_CTL-1:0] m_bus;
    word_t            tx_img;
    word_t            rx_img;
    word_t            misc_img;
    word_t            next_rdata;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;

    // index 0 is controller one, so it lands in the lane's low bit
    assign src_ts  = {ctl2_transmitting, ctl1_transmitting};
    assign src_tbs = {ctl2_tx_buffers_free, ctl1_tx_buffers_free};
    assign src_tcs = {ctl2_tx_complete, ctl1_tx_complete};
    assign src_rs  = {ctl2_receiving, ctl1_receiving};
    assign src_rb  = {ctl2_rx_frame_ready, ctl1_rx_frame_ready};
    assign src_dos = {ctl2_rx_overrun, ctl1_rx_overrun};
    assign src_err = {ctl2_error_warning, ctl1_error_warning};
    assign src_bus = {ctl2_bus_state, ctl1_bus_state};

    // one register stage so reads never see a half-changed source
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            m_ts  <= RST_LOW;
            m_tbs <= RST_HIGH;
            m_tcs <= RST_HIGH;
            m_rs  <= RST_LOW;
            m_rb  <= RST_LOW;
            m_dos <= RST_LOW;
            m_err <= RST_LOW;
            m_bus <= RST_LOW;
        end
        else
        begin
            m_ts  <= src_ts;
            m_tbs <= src_tbs;
            m_tcs <= src_tcs;
            m_rs  <= src_rs;
            m_rb  <= src_rb;
            m_dos <= src_dos;
            m_err <= src_err;
            m_bus <= src_bus;
        end
    end

    // reserved bits read as zero
    always_comb
    begin
        tx_img   = '0;
        rx_img   = '0;
        misc_img = '0;
        tx_img[LANE0 +: N_CTL]   = m_ts;
        tx_img[LANE1 +: N_CTL]   = m_tbs;
        tx_img[LANE2 +: N_CTL]   = m_tcs;
        rx_img[LANE0 +: N_CTL]   = m_rs;
        rx_img[LANE1 +: N_CTL]   = m_rb;
        rx_img[LANE2 +: N_CTL]   = m_dos;
        misc_img[LANE0 +: N_CTL] = m_err;
        misc_img[LANE1 +: N_CTL] = m_bus;
    end

    // ****************************************************************
    // events: rising edges of the flags software usually waits on
    // ****************************************************************

    genvar gi;
    generate
        for (gi = 0; gi < N_CTL; gi++)
        begin : g_evt
            assign evt_set[EV_RXRDY + gi] = src_rb[gi]  & ~m_rb[gi];
            assign evt_set[EV_OVR + gi]   = src_dos[gi] & ~m_dos[gi];
            assign evt_set[EV_ERR + gi]   = src_err[gi] & ~m_err[gi];
            assign evt_set[EV_BUS + gi]   = src_bus[gi] & ~m_bus[gi];
            assign evt_set[EV_TXC + gi]   = src_tcs[gi] & ~m_tcs[gi];
        end
    endgenerate

    // ****************************************************************
    // bus front and interrupt unit
    // ****************************************************************

    regbus_if bus ();

    apb_status_port apb_status_port_inst (
        .clk     (clk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus.front)
    );

    event_irq_unit event_irq_unit_inst (
        .clk     (clk),
        .rst     (rst),
        .bus     (bus.core),
        .evt_set (evt_set),
        .status  (evt_status),
        .mask    (evt_mask),
        .irq     (irq)
    );

    // ****************************************************************
    // read path
    // ****************************************************************

    // the full word is always returned; narrow reads pick their lanes
    always_comb
    begin
        next_rdata = '0;
        unique case (bus.setup_sel)
            SEL_TX:   next_rdata = tx_img;
            SEL_RX:   next_rdata = rx_img;
            SEL_MISC: next_rdata = misc_img;
            SEL_EVT:  next_rdata[EVT_W-1:0] = evt_status;
            SEL_MASK: next_rdata[EVT_W-1:0] = evt_mask;
            SEL_NONE: next_rdata = '0;
        endcase
    end

    // data is sampled at setup: it is the mirror state of that moment
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prdata <= '0;
        else if (bus.setup && !pwrite)
            prdata <= next_rdata;
    end

    // ****************************************************************
    // checks
    // ****************************************************************

    // the mirrors stay at their reset values for the edge after release,
    // whatever the sources show, so that edge is not compared
    chk_tx_lanes: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> tx_img[LANE0 +: N_CTL] == $past(src_ts))
        else $error("transmitting lanes do not follow sources");

    chk_tx_free: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> (tx_img[LANE1 +: N_CTL] == $past(src_tbs) &&
                         tx_img[LANE2 +: N_CTL] == $past(src_tcs)))
        else $error("buffer free or complete lanes wrong");

    chk_rx_image: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |->
        rx_img == ({14'h0000, $past(src_dos), 6'h00, $past(src_rb),
                    6'h00, $past(src_rs)}))
        else $error("receive status image wrong");

    chk_misc_image: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) |->
        misc_img == ({22'h000000, $past(src_bus), 6'h00,
                      $past(src_err)}))
        else $error("misc status image wrong");

    chk_reset_values: assert property (
        @(posedge clk) disable iff (rst)
        $past(rst) |-> (m_tbs == RST_HIGH && m_tcs == RST_HIGH &&
                        m_ts == RST_LOW && m_rs == RST_LOW &&
                        m_rb == RST_LOW && m_dos == RST_LOW &&
                        m_err == RST_LOW && m_bus == RST_LOW))
        else $error("mirror reset value wrong");

    chk_lane_order: assert property (
        @(posedge clk) disable iff (rst)
        (!$past(rst) && bus.setup && !pwrite &&
         bus.setup_sel == SEL_RX) ##1 1'b1
        |-> prdata[LANE1] == $past(ctl1_rx_frame_ready, 2) &&
            prdata[LANE1 + 1] == $past(ctl2_rx_frame_ready, 2))
        else $error("controller order in lane wrong");

    chk_read_current: assert property (
        @(posedge clk) disable iff (rst)
        (bus.setup && !pwrite && bus.setup_sel == SEL_MISC)
        |=> prdata == $past(misc_img) && pready && !pslverr)
        else $error("read did not return current status");

    chk_ro_refused: assert property (
        @(posedge clk) disable iff (rst)
        (bus.setup && pwrite && bus.setup_sel == SEL_TX)
        |=> pready && pslverr ##1 tx_img[LANE0 +: N_CTL] == $past(src_ts))
        else $error("write to read-only register accepted");

    chk_overrun_evt: assert property (
        @(posedge clk) disable iff (rst)
        $rose(m_dos[0]) |-> evt_status[EV_OVR])
        else $error("overrun rise did not set event flag");

    chk_bus_lane: assert property (
        @(posedge clk) disable iff (rst)
        $rose(ctl2_bus_state) ##1 ctl2_bus_state |-> misc_img[LANE1 + 1] [*2])
        else $error("bus state lane did not follow");

    chk_frame_lane: assert property (
        @(posedge clk) disable iff (rst)
        $fell(ctl1_rx_frame_ready) |=> !rx_img[LANE1])
        else $error("frame ready lane did not clear");

    chk_irq_level: assert property (
        @(posedge clk) disable iff (rst)
        (|(evt_status & evt_mask)) |=> irq)
        else $error("unmasked event without interrupt");

    chk_irq_clear: assert property (
        @(posedge clk) disable iff (rst)
        !(|(evt_status & evt_mask)) |=> !irq)
        else $error("interrupt without unmasked event");

    chk_event_sticky: assert property (
        @(posedge clk) disable iff (rst)
        (|evt_set) |=> ((evt_status & $past(evt_set)) == $past(evt_set)))
        else $error("event lost or overruled by a clear");

    chk_ready_once: assert property (
        @(posedge clk) disable iff (rst)
        bus.setup |=> pready ##1 !pready)
        else $error("ready not exactly one cycle after setup");

    chk_unmapped_err: assert property (
        @(posedge clk) disable iff (rst)
        (bus.setup && !pwrite && bus.setup_sel == SEL_NONE)
        |=> pslverr && prdata == '0)
        else $error("unmapped read not refused");

    chk_tx_read: assert property (
        @(posedge clk) disable iff (rst)
        (bus.setup && !pwrite && bus.setup_sel == SEL_TX)
        |=> prdata == $past(tx_img) && !pslverr)
        else $error("transmit status read wrong");

endmodule : central_can_status_regs

// ==== central_can_status_regs_tb.sv ====
/*
 * self-checking bench for the central CAN status bank: APB reads and
 * writes, mirror flags, refused writes, event flags, mask and interrupt.
 * assumes the zero-wait APB front and the event map of the design package.
 */
`timescale 1ns/100ps
module central_can_status_regs_tb;
    import can_central_pkg::*;

    // ********************************
    // signals and design instance
    // ********************************
    logic   clk;
    logic   rst;
    logic   psel;
    logic   penable;
    logic   pwrite;
    word_t  paddr;
    word_t  pwdata;
    logic   pready;
    word_t  prdata;
    logic   pslverr;
    logic   irq;
    // source flags, one vector per controller, index = flag kind:
    // 0 transmitting 1 buffers free 2 tx complete 3 receiving
    // 4 frame ready 5 overrun 6 error warning 7 bus state
    logic [7:0] s1;
    logic [7:0] s2;
    int         mismatches;
    int         cmp_count;
    int         cyc;
    word_t      rd;
    logic       err;
    word_t      raddr [3];
    int         kind_src [5];

    central_can_status_regs central_can_status_regs_inst (
        .clk                  (clk),
        .rst                  (rst),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .pready               (pready),
        .prdata               (prdata),
        .pslverr              (pslverr),
        .ctl1_transmitting    (s1[0]),
        .ctl2_transmitting    (s2[0]),
        .ctl1_tx_buffers_free (s1[1]),
        .ctl2_tx_buffers_free (s2[1]),
        .ctl1_tx_complete     (s1[2]),
        .ctl2_tx_complete     (s2[2]),
        .ctl1_receiving       (s1[3]),
        .ctl2_receiving       (s2[3]),
        .ctl1_rx_frame_ready  (s1[4]),
        .ctl2_rx_frame_ready  (s2[4]),
        .ctl1_rx_overrun      (s1[5]),
        .ctl2_rx_overrun      (s2[5]),
        .ctl1_error_warning   (s1[6]),
        .ctl2_error_warning   (s2[6]),
        .ctl1_bus_state       (s1[7]),
        .ctl2_bus_state       (s2[7]),
        .irq                  (irq)
    );

    always #10 clk = ~clk;

    // ********************************
    // helpers
    // ********************************
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic chk(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // holds the request until pready is seen high at a rising edge, giving up after 50 edges
    task automatic apb(input logic wr, input word_t addr, input word_t wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input word_t addr, input word_t exp, input logic e);
        apb(1'b0, addr, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, e});
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // image of register r worked out from the source vectors
    function automatic word_t exp_reg(input int r);
        word_t v;
        int    b;
        v = '0;
        for (int k = 0; k < 3; k++)
        begin
            b = 3 * r + k;
            if (b < 8)
            begin
                v[8*k] = s1[b];
                v[8*k+1] = s2[b];
            end
        end
        return v;
    endfunction : exp_reg

    // ********************************
    // timeout
    // ********************************
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // ********************************
    // main sequence
    // ********************************
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        s1 = 8'h06;
        s2 = 8'h06;
        mismatches = 0;
        cmp_count = 0;
        cyc = 0;
        raddr = '{ADDR_TX, ADDR_RX, ADDR_MISC};
        kind_src = '{4, 5, 6, 7, 2};
        idle(10);
        rst <= 1'b0;
        idle(2);
        rd_chk(ADDR_TX, 32'h0003_0300, 1'b0);
        rd_chk(ADDR_RX, 32'h0000_0000, 1'b0);
        rd_chk(ADDR_MISC, 32'h0000_0000, 1'b0);
        $display("test reset values done");

        // walking one over every source, then the source drops again
        for (int i = 0; i < 16; i++)
        begin
            s1 <= (i < 8) ? 8'(1 << i) : 8'h00;
            s2 <= (i < 8) ? 8'h00 : 8'(1 << (i - 8));
            idle(2);
            for (int r = 0; r < 3; r++)
                rd_chk(raddr[r], exp_reg(r), 1'b0);
        end
        s1 <= 8'h00;
        s2 <= 8'h00;
        idle(2);
        for (int r = 0; r < 3; r++)
            rd_chk(raddr[r], 32'h0000_0000, 1'b0);
        $display("test mirror lanes done");

        // writes to the status words are refused and change nothing
        s1 <= 8'hA5;
        s2 <= 8'h5A;
        idle(2);
        for (int r = 0; r < 3; r++)
        begin
            apb(1'b1, raddr[r], 32'h0000_0303);
            chk({31'h0, err}, 32'h0000_0001);
            rd_chk(raddr[r], exp_reg(r), 1'b0);
        end
        rd_chk(32'hE004_0014, 32'h0000_0000, 1'b1);
        rd_chk(32'h0000_0000, 32'h0000_0000, 1'b1);
        apb(1'b1, 32'hE004_0014, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        $display("test read-only and unmapped done");

        // each event: mask off, raise, unmask, clear
        for (int j = 0; j < 10; j++)
        begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            idle(2);
            apb(1'b1, ADDR_MASK, 32'h0000_0000);
            chk({31'h0, err}, 32'h0000_0000);
            apb(1'b1, ADDR_EVT, 32'h0000_03FF);
            rd_chk(ADDR_EVT, 32'h0000_0000, 1'b0);
            if (j % 2 == 0)
                s1[kind_src[j/2]] <= 1'b1;
            else
                s2[kind_src[j/2]] <= 1'b1;
            idle(3);
            rd_chk(ADDR_EVT, 32'(1 << j), 1'b0);
            chk({31'h0, irq}, 32'h0000_0000);
            apb(1'b1, ADDR_MASK, 32'(1 << j));
            rd_chk(ADDR_MASK, 32'(1 << j), 1'b0);
            idle(2);
            chk({31'h0, irq}, 32'h0000_0001);
            apb(1'b1, ADDR_EVT, 32'(1 << j));
            idle(2);
            chk({31'h0, irq}, 32'h0000_0000);
            rd_chk(ADDR_EVT, 32'h0000_0000, 1'b0);
        end
        $display("test events and interrupt done");
        wrap_up();
    end

endmodule : central_can_status_regs_tb

// ==== event_irq_unit.sv ====
/*
 * sticky event flags, write-one-to-clear, mask and level interrupt.
 * assumes one-cycle event pulses and commit from the APB front.
 */
`timescale 1ns/100ps
module event_irq_unit
    import can_central_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    regbus_if.core                     bus,
    input  wire logic [EVT_W-1:0]      evt_set,
    output logic      [EVT_W-1:0]      status,
    output logic      [EVT_W-1:0]      mask,
    output logic                       irq
);
    logic [EVT_W-1:0] clr;

    assign clr = (bus.commit && bus.cmt_write && bus.cmt_sel == SEL_EVT)
                 ? bus.cmt_wdata[EVT_W-1:0] : '0;

    // a new event wins over a clear landing in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            status <= '0;
        else
            status <= (status & ~clr) | evt_set;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mask <= '0;
        else if (bus.commit && bus.cmt_write && bus.cmt_sel == SEL_MASK)
            mask <= bus.cmt_wdata[EVT_W-1:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status & mask);
    end
endmodule : event_irq_unit

// ==== regbus_if.sv ====
/*
 * internal request carrier between the APB front and the register logic.
 * assumes one clock; setup fields and commit are combinational, cmt_sel, cmt_write and cmt_wdata flopped.
 */
`timescale 1ns/100ps
interface regbus_if
    import can_central_pkg::*;
();
    logic     setup;
    reg_sel_t setup_sel;
    logic     commit;
    reg_sel_t cmt_sel;
    logic     cmt_write;
    word_t    cmt_wdata;

    modport front (output setup, setup_sel, commit, cmt_sel, cmt_write,
                   cmt_wdata);
    modport core  (input  setup, setup_sel, commit, cmt_sel, cmt_write,
                   cmt_wdata);
endinterface : regbus_if
